// ---- inc/isx_pkg.sv ----
/*
  package for the increment, skip, software interrupt and indirect
  program-memory access execute block: opcodes, timing counts, region map,
  decoded-instruction and memory-request carriers.
  assumes: one core clock; region boundaries below suit the memory map.
*/
package isx_pkg;

  // ----------------------------------------------------------------
  // widths and opcode fields
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned OP7_LSB = 9;
  localparam logic [6:0] OP7_INC_MEM = 7'h15;
  localparam logic [6:0] OP7_INC_ACC = 7'h14;
  localparam logic [6:0] OP7_INCSNZ_MEM = 7'h2D;
  localparam logic [6:0] OP7_INCSNZ_ACC = 7'h2C;
  localparam logic [6:0] OP7_INCSZ_MEM = 7'h1F;
  localparam logic [6:0] OP7_INCSZ_ACC = 7'h1E;
  localparam logic [6:0] OP7_PAGE_LOAD = 7'h38;
  localparam logic [15:0] OP_SWI = 16'h0006;
  localparam logic [15:0] OP_IREAD = 16'h0019;
  localparam logic [15:0] OP_IREADI = 16'h001D;
  localparam logic [15:0] OP_IWRITE = 16'h0018;

  // ----------------------------------------------------------------
  // arithmetic constants and cycle counts
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] ADDR_LO_STEP = 8'h02;
  localparam int unsigned BLOCK_CYCLES = 4;
  localparam int unsigned SWI_CYCLES = 3;
  localparam int unsigned HOLD_W = 2;
  localparam logic [HOLD_W-1:0] HOLD_BLOCK = HOLD_W'(BLOCK_CYCLES - 1);
  localparam logic [HOLD_W-1:0] HOLD_SWI = HOLD_W'(SWI_CYCLES - 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = 2'h1;
  localparam logic [HOLD_W-1:0] HOLD_STEP = 2'h1;
  localparam logic [HOLD_W-1:0] HOLD_IDLE = 2'h0;

  // ----------------------------------------------------------------
  // program memory region map
  // ----------------------------------------------------------------
  localparam logic [23:0] PRAM_LAST = 24'h00_FFFF;
  localparam logic [23:0] FLASH_LAST = 24'h01_FFFF;

  typedef enum logic [1:0] {
    RG_PRAM = 2'h0,
    RG_FLASH = 2'h1,
    RG_EXT = 2'h2
  } isx_region_t;

  typedef enum logic [1:0] {
    PK_NONE = 2'h0,
    PK_READ = 2'h1,
    PK_READI = 2'h2,
    PK_WRITE = 2'h3
  } isx_pkind_t;

  typedef struct packed {
    logic inc_mem;
    logic inc_acc;
    logic flag_upd;
    logic skip_nz;
    logic skip_z;
    logic swi;
    logic page_load;
    isx_pkind_t pkind;
  } isx_dec_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } isx_pmem_req_t;

  // which memory a 24-bit program address falls in
  function automatic isx_region_t isx_region(input logic [ADDR_W-1:0] a);
    if (a <= PRAM_LAST) begin
      return RG_PRAM;
    end else if (a <= FLASH_LAST) begin
      return RG_FLASH;
    end
    return RG_EXT;
  endfunction

endpackage

// ---- hdl/isx_decode.sv ----
/*
  instruction classifier for the increment family, software interrupt and
  indirect program-memory accesses.
  assumes: purely combinational, fed from the instruction register.
*/
`timescale 1ns/1ns
module isx_decode
  import isx_pkg::*;
(
  input wire logic [WORD_W-1:0] i_instr,
  output isx_dec_t o_dec
);

  logic [6:0] op7;

  // ----------------------------------------------------------------
  // opcode field match
  // ----------------------------------------------------------------
  assign op7 = i_instr[WORD_W-1:OP7_LSB];

  always_comb begin
    o_dec = '0;
    o_dec.inc_mem = (op7 == OP7_INC_MEM) || (op7 == OP7_INCSNZ_MEM) ||
                    (op7 == OP7_INCSZ_MEM);
    o_dec.inc_acc = (op7 == OP7_INC_ACC) || (op7 == OP7_INCSNZ_ACC) ||
                    (op7 == OP7_INCSZ_ACC);
    o_dec.flag_upd = (op7 == OP7_INC_MEM) || (op7 == OP7_INC_ACC);
    o_dec.skip_nz = (op7 == OP7_INCSNZ_MEM) || (op7 == OP7_INCSNZ_ACC);
    o_dec.skip_z = (op7 == OP7_INCSZ_MEM) || (op7 == OP7_INCSZ_ACC);
    o_dec.page_load = (op7 == OP7_PAGE_LOAD);
    o_dec.swi = (i_instr == OP_SWI);
    if (i_instr == OP_IREAD) begin
      o_dec.pkind = PK_READ;
    end else if (i_instr == OP_IREADI) begin
      o_dec.pkind = PK_READI;
    end else if (i_instr == OP_IWRITE) begin
      o_dec.pkind = PK_WRITE;
    end else begin
      o_dec.pkind = PK_NONE;
    end
  end

endmodule

// ---- hdl/isx_pmem.sv ----
/*
  indirect program-memory access sequencer: target decode, blocking choice,
  request issue, read-data return, low address step and flash busy flag.
  assumes: one access outstanding at a time; memory answers with i_ack.
*/
`timescale 1ns/1ns
module isx_pmem
  import isx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_issue,
  input isx_pkind_t i_kind,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [WORD_W-1:0] i_wdata,
  input wire logic i_exec_from_ram,
  input wire logic i_ack,
  input wire logic [WORD_W-1:0] i_rdata,
  output logic o_block,
  output logic o_req_valid,
  output isx_pmem_req_t o_req,
  output logic o_data_we,
  output logic [WORD_W-1:0] o_data_word,
  output logic o_addr_lo_we,
  output logic [BYTE_W-1:0] o_addr_lo,
  output logic o_flash_busy,
  output logic o_fetch_inhibit
);

  isx_region_t region;
  logic legal;
  logic go;
  logic rd_pend_r;
  logic fl_pend_r;
  logic busy_nxt;

  // ----------------------------------------------------------------
  // target legality and blocking choice
  // ----------------------------------------------------------------
  assign region = isx_region(i_addr);

  always_comb begin
    legal = 1'b0;
    o_block = 1'b0;
    unique case (i_kind)
      PK_READ: begin
        legal = 1'b1;
        o_block = (region == RG_PRAM) || (region == RG_FLASH && !i_exec_from_ram);
      end
      PK_READI: begin
        legal = (region != RG_EXT);
        o_block = (region == RG_PRAM) || (region == RG_FLASH && !i_exec_from_ram);
      end
      PK_WRITE: begin
        legal = (region != RG_FLASH);
        o_block = (region == RG_PRAM);
      end
      PK_NONE: begin
        legal = 1'b0;
      end
    endcase
    o_block = o_block && legal && i_issue;
  end

  assign go = i_issue && legal;

  // ----------------------------------------------------------------
  // request issue and low address step
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_req_valid <= 1'b0;
      o_req <= '0;
      o_addr_lo_we <= 1'b0;
      o_addr_lo <= '0;
    end else begin
      o_req_valid <= go;
      if (go) begin
        o_req <= '{we: (i_kind == PK_WRITE), addr: i_addr, wdata: i_wdata};
      end
      o_addr_lo_we <= go && (i_kind == PK_READI);
      // stepped byte only moves with its write strobe, so it holds between accesses
      if (go && (i_kind == PK_READI)) begin
        o_addr_lo <= i_addr[BYTE_W-1:0] + ADDR_LO_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // read return into the data pair
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_pend_r <= 1'b0;
      o_data_we <= 1'b0;
      o_data_word <= '0;
    end else begin
      o_data_we <= i_ack && rd_pend_r;
      if (i_ack && rd_pend_r) begin
        o_data_word <= i_rdata;
      end
      if (go) begin
        rd_pend_r <= (i_kind != PK_WRITE); // new issue wins over ack
      end else if (i_ack) begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flash busy: set by a background flash access, cleared on its ack
  // ----------------------------------------------------------------
  assign busy_nxt = (go && region == RG_FLASH && !o_block) ? 1'b1 :
                    (i_ack && fl_pend_r) ? 1'b0 : fl_pend_r;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fl_pend_r <= 1'b0;
      o_flash_busy <= 1'b0;
      o_fetch_inhibit <= 1'b0;
    end else begin
      fl_pend_r <= busy_nxt;
      o_flash_busy <= busy_nxt;
      o_fetch_inhibit <= busy_nxt;
    end
  end

endmodule

// ---- hdl/isx_exec.sv ----
/*
  execute stage for the increment family, increment-and-skip, software
  interrupt and indirect program-memory read/write instructions.
  assumes: instruction, operand byte and address/data registers come from
  core-clock logic; the fetch stage holds an instruction until accepted.
*/
`timescale 1ns/1ns

module isx_exec
  import isx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_valid,
  input wire logic [WORD_W-1:0] i_instr,
  input wire logic [BYTE_W-1:0] i_mem_operand,
  input wire logic i_global_irq_enable,
  input wire logic i_int_entry,
  input wire logic i_exec_from_ram,
  input wire logic [BYTE_W-1:0] i_addr_ext,
  input wire logic [BYTE_W-1:0] i_addr_hi,
  input wire logic [BYTE_W-1:0] i_addr_lo,
  input wire logic [BYTE_W-1:0] i_data_hi,
  input wire logic [BYTE_W-1:0] i_data_lo,
  input wire logic i_pmem_ack,
  input wire logic [WORD_W-1:0] i_pmem_rdata,
  output logic o_stall,
  output logic o_squash,
  output logic o_mem_we,
  output logic [BYTE_W-1:0] o_mem_wdata,
  output logic o_acc_we,
  output logic [BYTE_W-1:0] o_acc_data,
  output logic o_zflag_we,
  output logic o_zflag,
  output logic o_irq_req,
  output logic o_pmem_valid,
  output isx_pmem_req_t o_pmem_req,
  output logic o_data_we,
  output logic [WORD_W-1:0] o_data_word,
  output logic o_addr_lo_we,
  output logic [BYTE_W-1:0] o_addr_lo,
  output logic o_flash_busy_flag,
  output logic o_flash_fetch_inhibit
);

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } isx_state_t;

  isx_dec_t dec;
  isx_state_t state_r;
  isx_state_t state_nxt;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic [HOLD_W-1:0] hold_nxt;
  logic skip_pend_r;
  logic accept;
  logic squash;
  logic exec;
  logic [BYTE_W-1:0] sum;
  logic sum_zero;
  logic skip_take;
  logic swi_fire;
  logic pm_issue;
  logic pm_block;
  logic [ADDR_W-1:0] pm_addr;
  logic [WORD_W-1:0] pm_word;

  // ----------------------------------------------------------------
  // decode and issue qualification
  // ----------------------------------------------------------------
  isx_decode u_decode (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  assign accept = i_instr_valid && (state_r == ST_RUN);
  assign squash = accept && skip_pend_r;
  assign exec = accept && !skip_pend_r;

  // increment result and skip test
  assign sum = i_mem_operand + BYTE_ONE;
  assign sum_zero = (sum == BYTE_ZERO);
  assign skip_take = (dec.skip_nz && !sum_zero) || (dec.skip_z && sum_zero);
  assign swi_fire = exec && dec.swi && i_global_irq_enable && !i_int_entry;
  assign pm_issue = exec && (dec.pkind != PK_NONE);

  // address and word assembly, most significant byte first
  assign pm_addr = {i_addr_ext, i_addr_hi, i_addr_lo};
  assign pm_word = {i_data_hi, i_data_lo};

  // ----------------------------------------------------------------
  // program memory access sequencer
  // ----------------------------------------------------------------
  isx_pmem u_pmem (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_issue(pm_issue),
    .i_kind(dec.pkind),
    .i_addr(pm_addr),
    .i_wdata(pm_word),
    .i_exec_from_ram(i_exec_from_ram),
    .i_ack(i_pmem_ack),
    .i_rdata(i_pmem_rdata),
    .o_block(pm_block),
    .o_req_valid(o_pmem_valid),
    .o_req(o_pmem_req),
    .o_data_we(o_data_we),
    .o_data_word(o_data_word),
    .o_addr_lo_we(o_addr_lo_we),
    .o_addr_lo(o_addr_lo),
    .o_flash_busy(o_flash_busy_flag),
    .o_fetch_inhibit(o_flash_fetch_inhibit)
  );

  // ----------------------------------------------------------------
  // hold sequencer for multi-cycle instructions
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_cnt_r;
    unique case (state_r)
      ST_RUN: begin
        if (exec && dec.swi) begin
          state_nxt = ST_HOLD;
          hold_nxt = HOLD_SWI;
        end else if (pm_block) begin
          state_nxt = ST_HOLD;
          hold_nxt = HOLD_BLOCK;
        end
      end
      ST_HOLD: begin
        if (hold_cnt_r == HOLD_LAST) begin
          state_nxt = ST_RUN;
          hold_nxt = HOLD_IDLE;
        end else begin
          hold_nxt = hold_cnt_r - HOLD_STEP;
        end
      end
      default: begin
        state_nxt = ST_RUN;
        hold_nxt = HOLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_RUN;
      hold_cnt_r <= HOLD_IDLE;
      o_stall <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_nxt;
      o_stall <= (state_nxt == ST_HOLD);
    end
  end

  // ----------------------------------------------------------------
  // skip tracking and squash of the following instruction
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      skip_pend_r <= 1'b0;
      o_squash <= 1'b0;
    end else begin
      o_squash <= squash;
      if (squash) begin
        skip_pend_r <= dec.page_load;
      end else if (exec) begin
        skip_pend_r <= skip_take;
      end
    end
  end

  // ----------------------------------------------------------------
  // increment write-back: memory, accumulator and zero flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= '0;
      o_acc_we <= 1'b0;
      o_acc_data <= '0;
    end else begin
      o_mem_we <= exec && dec.inc_mem;
      o_acc_we <= exec && dec.inc_acc;
      if (exec && (dec.inc_mem || dec.inc_acc)) begin
        o_mem_wdata <= sum;
        o_acc_data <= sum;
      end
    end
  end

  // only the plain increments touch the zero flag
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_zflag_we <= 1'b0;
      o_zflag <= 1'b0;
    end else begin
      o_zflag_we <= exec && dec.flag_upd;
      if (exec && dec.flag_upd) begin
        o_zflag <= sum_zero;
      end
    end
  end

  // software interrupt request pulse
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= swi_fire;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_inc_mem_zero;
    exec && dec.inc_mem && dec.flag_upd |=>
      o_mem_we && o_zflag_we && (o_zflag == (o_mem_wdata == BYTE_ZERO)) &&
      (o_mem_wdata == $past(i_mem_operand) + BYTE_ONE);
  endproperty
  a_inc_mem_zero: assert property (p_inc_mem_zero) else $error("inc mem result wrong");

  property p_inc_acc_only;
    exec && dec.inc_acc && dec.flag_upd |=>
      o_acc_we && !o_mem_we && o_zflag_we && (o_zflag == (o_acc_data == BYTE_ZERO));
  endproperty
  a_inc_acc_only: assert property (p_inc_acc_only) else $error("inc acc wrong");

  property p_skip_nz;
    exec && dec.skip_nz && (i_mem_operand != 8'hFF) |=> skip_pend_r && !o_zflag_we;
  endproperty
  a_skip_nz: assert property (p_skip_nz) else $error("nonzero skip missed");

  property p_skip_z;
    exec && dec.skip_z |=> (skip_pend_r == ($past(i_mem_operand) == 8'hFF));
  endproperty
  a_skip_z: assert property (p_skip_z) else $error("zero skip wrong");

  property p_skip_two_cycles;
    exec && skip_take && (dec.skip_nz || dec.skip_z) ##1 i_instr_valid |=>
      o_squash && !o_mem_we && !o_acc_we && !o_zflag_we;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not squashed");

  property p_swi_gate;
    exec && dec.swi |=> (o_irq_req == $past(i_global_irq_enable && !i_int_entry)) &&
      o_stall ##1 o_stall ##1 !o_stall;
  endproperty
  a_swi_gate: assert property (p_swi_gate) else $error("soft interrupt wrong");

  property p_block_four;
    pm_block |=> o_stall [*3] ##1 !o_stall;
  endproperty
  a_block_four: assert property (p_block_four) else $error("blocking hold wrong");

  property p_extended_skip;
    squash && dec.page_load ##1 i_instr_valid |=> o_squash;
  endproperty
  a_extended_skip: assert property (p_extended_skip) else $error("extended skip lost");

  property p_flash_busy;
    o_flash_busy_flag && !i_pmem_ack |=> o_flash_busy_flag && o_flash_fetch_inhibit;
  endproperty
  a_flash_busy: assert property (p_flash_busy) else $error("flash busy dropped");

  c_skip: cover property (exec && skip_take ##1 squash);
  c_swi: cover property (swi_fire);
  c_block: cover property (pm_block);
  c_bg_flash: cover property ($rose(o_flash_busy_flag));

endmodule

// ---- test/isx_pmem_model.sv ----
/*
  program memory model for the execute block: answers every request two
  cycles after it and keeps the last write it was given.
  assumes: one request outstanding; requests arrive as one-cycle pulses.
*/
`timescale 1ns/1ns
module isx_pmem_model
  import isx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_valid,
  input isx_pmem_req_t i_req,
  output logic o_ack,
  output logic [WORD_W-1:0] o_rdata,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [WORD_W-1:0] o_wr_word
);
  logic pend_r;
  logic [ADDR_W-1:0] addr_r;

  // ----------------------------------------------------------------
  // answer and write capture
  // ----------------------------------------------------------------
  initial begin
    pend_r = 1'b0;
    addr_r = 24'h00_0000;
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    o_wr_addr = 24'h00_0000;
    o_wr_word = 16'h0000;
  end

  // read word is a pattern of the address; between answers it toggles
  always @(posedge i_core_clk) begin
    o_ack <= pend_r;
    o_rdata <= pend_r ? (addr_r[15:0] ^ 16'h5A3C) : ~o_rdata;
    pend_r <= i_valid;
    if (i_valid) begin
      addr_r <= i_req.addr;
    end
    if (i_valid && i_req.we) begin
      o_wr_addr <= i_req.addr;
      o_wr_word <= i_req.wdata;
    end
  end
endmodule

// ---- test/tb_incr_skip_and_progmem_access_exec.sv ----
/*
  self-checking bench for the execute block: increment table, skip
  chains, software interrupt and indirect program-memory accesses.
  assumes: the memory model answers two cycles after each request.
*/
`timescale 1ns/1ns
module tb_incr_skip_and_progmem_access_exec
  import isx_pkg::*;
;
  typedef struct packed {
    logic [15:0] i;
    logic [7:0] o;
    logic mw, aw, zw, z;
    logic [7:0] r;
    logic s;
  } isx_row_t;
  typedef struct packed {
    logic [15:0] op;
    logic [23:0] a;
    logic rm, v, we;
    logic [1:0] c;
    logic fb;
  } isx_prow_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld, efr, irq_en, ent, ack;
  logic [15:0] ins, rd, dw, wrw;
  logic [7:0] opd, ax, ah, al, dh, dl, mwd, ad, alo;
  logic stall, sq, mwe, awe, zwe, z, irq, pv, dwe, alwe, fb, fi;
  logic [23:0] wra;
  isx_pmem_req_t req;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  // inputs, operand and results of the increment family
  isx_row_t rows [12] = '{
    '{16'h2A99, 8'hFF, 1, 0, 1, 1, 8'h00, 0},
    '{16'h2B10, 8'h75, 1, 0, 1, 0, 8'h76, 0},
    '{16'h2899, 8'hFF, 0, 1, 1, 1, 8'h00, 0},
    '{16'h2899, 8'h75, 0, 1, 1, 0, 8'h76, 0},
    '{16'h5A99, 8'h10, 1, 0, 0, 0, 8'h11, 1},
    '{16'h5A99, 8'hFF, 1, 0, 0, 0, 8'h00, 0},
    '{16'h5899, 8'h75, 0, 1, 0, 0, 8'h76, 1},
    '{16'h5899, 8'hFF, 0, 1, 0, 0, 8'h00, 0},
    '{16'h3E99, 8'hFF, 1, 0, 0, 0, 8'h00, 1},
    '{16'h3E99, 8'h10, 1, 0, 0, 0, 8'h11, 0},
    '{16'h3C99, 8'hFF, 0, 1, 0, 0, 8'h00, 1},
    '{16'h3C99, 8'h7F, 0, 1, 0, 0, 8'h80, 0}
  };
  // indirect accesses: target, code origin and expected issue and stall
  isx_prow_t pt [11] = '{
    '{16'h0019, 24'h00_0380, 0, 1, 0, 3, 0},
    '{16'h0019, 24'h01_8380, 0, 1, 0, 3, 0},
    '{16'h0019, 24'h01_8390, 1, 1, 0, 0, 1},
    '{16'h0019, 24'h02_0010, 0, 1, 0, 0, 0},
    '{16'h001D, 24'h00_03FE, 0, 1, 0, 3, 0},
    '{16'h001D, 24'h01_83A0, 1, 1, 0, 0, 1},
    '{16'h001D, 24'h01_83B0, 0, 1, 0, 3, 0},
    '{16'h001D, 24'h02_0020, 1, 0, 0, 0, 0},
    '{16'h0018, 24'h00_0480, 0, 1, 1, 3, 0},
    '{16'h0018, 24'h03_0000, 0, 1, 1, 0, 0},
    '{16'h0018, 24'h01_0480, 1, 0, 0, 0, 0}
  };

  // ----------------------------------------------------------------
  // design, memory model, clock and cycle limit
  // ----------------------------------------------------------------
  isx_exec isx_exec_i (
    .i_core_clk(clk), .i_sys_rst(rst), .i_instr_valid(vld), .i_instr(ins),
    .i_mem_operand(opd), .i_global_irq_enable(irq_en), .i_int_entry(ent),
    .i_exec_from_ram(efr), .i_addr_ext(ax), .i_addr_hi(ah), .i_addr_lo(al),
    .i_data_hi(dh), .i_data_lo(dl), .i_pmem_ack(ack), .i_pmem_rdata(rd),
    .o_stall(stall), .o_squash(sq), .o_mem_we(mwe), .o_mem_wdata(mwd),
    .o_acc_we(awe), .o_acc_data(ad), .o_zflag_we(zwe), .o_zflag(z),
    .o_irq_req(irq), .o_pmem_valid(pv), .o_pmem_req(req), .o_data_we(dwe),
    .o_data_word(dw), .o_addr_lo_we(alwe), .o_addr_lo(alo),
    .o_flash_busy_flag(fb), .o_flash_fetch_inhibit(fi));
  isx_pmem_model isx_pmem_model_i (
    .i_core_clk(clk), .i_valid(pv), .i_req(req), .o_ack(ack), .o_rdata(rd),
    .o_wr_addr(wra), .o_wr_word(wrw));

  initial begin
    forever #50 clk = ~clk;
  end

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // present an instruction at a falling edge; it is taken at the next rise
  task automatic put(input logic [15:0] i, input logic [7:0] o);
    chk(stall, 0);
    vld = 1'b1;
    ins = i;
    opd = o;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic idle();
    vld = 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  // count the further stalled cycles after an accept
  task automatic hold(output int c);
    c = 0;
    vld = 1'b0;
    while (stall === 1'b1 && c < 8) begin
      @(posedge clk);
      @(negedge clk);
      c++;
    end
  endtask

  task automatic complete_run();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    vld = 0;
    ins = 0;
    opd = 0;
    efr = 0;
    irq_en = 0;
    ent = 0;
    {ax, ah, al, dh, dl} = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({stall, sq, pv, fb, irq, mwe}, 0);
    rst = 1'b0;
    // table: result, then follower squashed or executed
    for (int k = 0; k < 12; k++) begin
      put(rows[k].i, rows[k].o);
      chk({mwe, awe}, {rows[k].mw, rows[k].aw});
      chk(zwe, rows[k].zw);
      if (rows[k].zw) chk(z, rows[k].z);
      chk(rows[k].mw ? mwd : ad, rows[k].r);
      put(16'h2A99, 8'h20);
      chk(sq, rows[k].s);
      chk(mwe, !rows[k].s);
      idle();
      chk({sq, mwe}, 2'b00);
    end
    // skipped page load extends the skip by one
    put(16'h3E99, 8'hFF);
    put(16'h7000, 8'h00);
    chk(sq, 1);
    put(16'h2A99, 8'h20);
    chk({sq, mwe}, 2'b10);
    put(16'h2A99, 8'h20);
    chk({sq, mwe}, 2'b01);
    idle();
    // software interrupt under every enable and entry mix
    for (int k = 0; k < 4; k++) begin
      {irq_en, ent} = 2'(k);
      put(16'h0006, 8'h00);
      chk({irq, zwe}, {irq_en & !ent, 1'b0});
      hold(n);
      chk(n, 2);
      idle();
    end
    // indirect accesses
    for (int k = 0; k < 11; k++) begin
      efr = pt[k].rm;
      {ax, ah, al} = pt[k].a;
      dh = pt[k].a[15:8] ^ 8'h3C;
      dl = ~al;
      put(pt[k].op, 8'h00);
      chk(pv, pt[k].v);
      chk(alwe, (pt[k].op == 16'h001D) && pt[k].v);
      if (pt[k].v) chk({req.we, req.addr}, {pt[k].we, pt[k].a});
      if (pt[k].we) chk(req.wdata, {dh, dl});
      chk({fb, fi}, {pt[k].fb, pt[k].fb});
      hold(n);
      chk(n, pt[k].c);
      chk(dwe, (pt[k].c != 0) && !pt[k].we);
      repeat (3) idle();
      chk({fb, fi}, 2'b00);
      if (pt[k].v && !pt[k].we) chk(dw, pt[k].a[15:0] ^ 16'h5A3C);
      if (pt[k].we) chk({wra, wrw}, {pt[k].a, dh, dl});
      if (pt[k].op == 16'h001D && pt[k].v) chk(alo, 8'(al + 8'h02));
    end
    // reset in the middle of a blocking access
    efr = 1'b0;
    {ax, ah, al} = 24'h00_0500;
    put(16'h0019, 8'h00);
    rst = 1'b1;
    vld = 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({stall, pv, fb}, 3'b000);
    rst = 1'b0;
    put(16'h2A99, 8'h41);
    chk({mwe, mwd}, {1'b1, 8'h42});
    idle();
    complete_run();
  end
endmodule
